// ==== bench/cmf_chk.sv ====
`timescale 1ns/1ps
// ==========================================================================
// Port checks of register bus timing, reserved bits and acceptance
module cmf_chk (
  // Clock and reset
  input logic        I_MCLK,
  input logic        I_RST,
  // Register bus
  input logic [6:0]  I_AVS_ADDRESS,
  input logic        I_AVS_READ,
  input logic        I_AVS_WRITE,
  input logic [31:0] I_AVS_WRITEDATA,
  input logic [3:0]  I_AVS_BYTEENABLE,
  input logic [31:0] O_AVS_READDATA,
  input logic        O_AVS_WAITREQUEST,
  // Receive side
  input logic        I_RX_VALID,
  input logic        O_RX_ACCEPT,
  input logic [7:0]  O_RX_MATCH_INDEX,
  input logic        O_RX_FULL
);
  logic [2:0] page_ff;
  logic       rd_ans;
  // Shadow of the page number from completed writes
  always_ff @(posedge I_MCLK) begin
    if (I_RST)
      page_ff <= 3'h0;
    else if (I_AVS_WRITE && !O_AVS_WAITREQUEST && I_AVS_ADDRESS == 7'h60 && I_AVS_BYTEENABLE[0])
      page_ff <= I_AVS_WRITEDATA[2:0];
  end
  // Read answer sampled by the master
  assign rd_ans = I_AVS_READ && !O_AVS_WAITREQUEST;
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_RST);
  a_wait_two_cycles: assert property ($rose(I_AVS_READ || I_AVS_WRITE) |->
    O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST ##1 !O_AVS_WAITREQUEST)
    else $error("answer not two cycles after request");
  a_wait_one_low: assert property (!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
    else $error("waitrequest low too long");
  a_cfg_resv_zero: assert property (rd_ans && page_ff == 3'h6 && I_AVS_ADDRESS inside {7'h7A,
    7'h7B, 7'h7C} |-> O_AVS_READDATA[7] == 1'b0 && O_AVS_READDATA[3] == 1'b0)
    else $error("config reserved bit set");
  a_mode_top_zero: assert property (rd_ans && page_ff == 3'h6 && I_AVS_ADDRESS == 7'h79
    |-> O_AVS_READDATA[7:4] == 4'h0) else $error("mode top nibble set");
  a_len_top_zero: assert property (rd_ans && page_ff inside {3'h0, 3'h1, 3'h7}
    && I_AVS_ADDRESS == 7'h71 |-> O_AVS_READDATA[7:4] == 4'h0) else $error("length top set");
  a_accept_cause: assert property (O_RX_ACCEPT |-> $past(I_RX_VALID))
    else $error("accept without frame");
  a_accept_full: assert property (O_RX_ACCEPT |-> O_RX_FULL)
    else $error("accept without full mailbox");
  a_index_hold: assert property ($changed(O_RX_MATCH_INDEX) |-> O_RX_ACCEPT)
    else $error("match index moved without accept");
  a_reset_idle: assert property ($fell(I_RST) |-> O_AVS_WAITREQUEST && !O_RX_ACCEPT
    && !O_RX_FULL && O_RX_MATCH_INDEX == 8'h00 && O_AVS_READDATA == 32'h0)
    else $error("outputs not idle after reset");
endmodule // cmf_chk

bind cmf_top cmf_chk u_cmf_chk (.*);

// ==== bench/cmf_xcvr.sv ====
`timescale 1ns/1ps
// ==========================================================================
// Transceiver side: hands one received frame per command
module cmf_xcvr (
  // Clock and command
  input  logic        i_clk,
  input  logic        i_send,
  input  logic        i_slow,
  input  logic [31:0] i_key,
  input  logic [3:0]  i_len,
  input  logic [63:0] i_data,
  // Frame toward the controller
  output logic        o_valid,
  output logic [28:0] o_id,
  output logic        o_ide,
  output logic        o_rtr,
  output logic [3:0]  o_len,
  output logic [63:0] o_data
);
  initial {o_valid, o_id, o_ide, o_rtr, o_len, o_data} = '0;
  // Frame pulse, optionally late; fields scrambled once released
  always @(posedge i_clk) begin
    if (i_send) begin
      repeat (i_slow ? 6 : 0) @(posedge i_clk);
      o_valid <= 1'b1;
      {o_id, o_ide, o_rtr} <= i_key[31:1];
      o_len <= i_len;
      o_data <= i_data;
      @(posedge i_clk);
      o_valid <= 1'b0;
      {o_id, o_ide, o_rtr, o_len, o_data} <= ~{o_id, o_ide, o_rtr, o_len, o_data};
    end
  end
endmodule // cmf_xcvr

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
// ==========================================================================
// Bench with a register and acceptance model
module tb_top;
  import cmf_pkg::*;
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, snd = 1'b0, slow = 1'b0;
  logic [6:0] adr = 7'h00;
  logic [31:0] wd = 32'h0, key = 32'h0, rq;
  logic [3:0] be = 4'hF, ln = 4'h0, xln;
  logic [1:0] txe = 2'h3;
  logic [63:0] dt = 64'h0, xdt;
  logic wq, acc_o, full, xv, xide, xrtr;
  logic [7:0] idx, m_idx = 8'h00;
  logic [28:0] xid;
  logic [7:0] m_win[8][16];
  logic [2:0] m_pg = 3'h0;
  bit m_full = 1'b0;
  int n_fail = 0, checked = 0;
  int pgs[6] = '{0, 1, 0, 1, 5, 7};
  // Design, far side and clock
  cmf_top u_cmf_top (.I_MCLK(clk), .I_RST(rst), .I_CE(1'b1), .I_AVS_ADDRESS(adr),
    .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(be),
    .O_AVS_READDATA(rq), .O_AVS_WAITREQUEST(wq), .I_TX_EMPTY(txe), .I_RX_VALID(xv),
    .I_RX_ID(xid), .I_RX_IDE(xide), .I_RX_RTR(xrtr), .I_RX_DLC(xln), .I_RX_DATA(xdt),
    .O_RX_ACCEPT(acc_o), .O_RX_MATCH_INDEX(idx), .O_RX_FULL(full));
  cmf_xcvr u_xcvr (.i_clk(clk), .i_send(snd), .i_slow(slow), .i_key(key), .i_len(ln),
    .i_data(dt), .o_valid(xv), .o_id(xid), .o_ide(xide), .o_rtr(xrtr), .o_len(xln),
    .o_data(xdt));
  always #2 clk = ~clk;
  // ========================================================================
  // Verdict and compares
  task automatic tally_and_finish();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic hang();
    n_fail++;
    $display("mismatch t=%0t wait ran out", $time);
    tally_and_finish();
  endtask
  task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch t=%0t read %h exp %h at %h page %0d", $time, g, e, adr, m_pg);
    end
  endtask
  task automatic cmp_rx(input logic [9:0] g, input logic [9:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch t=%0t accept/full/index %h exp %h", $time, g, e);
    end
  endtask
  // ========================================================================
  // Model of the register file and filters
  function automatic logic [31:0] fpat(input int f, input int h);
    logic [31:0] p;
    for (int i = 0; i < 4; i++) p = {p[23:0], m_win[2 + f / 2][8 * (f % 2) + 4 * h + i]};
    return p;
  endfunction
  function automatic bit fhit(input int f, input logic [31:0] k);
    logic [7:0] c, md;
    logic [31:0] p;
    logic [15:0] k16;
    c = m_win[6][10 + f / 2] >> (4 * (f % 2));
    md = m_win[6][8 + f / 4] >> (2 * (f % 4));
    if (!c[0]) return 1'b0;
    // 16-bit scales: key window per scale, each half id pair then mask pair
    if (c[2:1] != 2'h3) begin
      k16 = 16'(k >> (16 - 8 * c[2:1]));
      for (int h = 0; h < 2; h++) begin
        p = fpat(f, h);
        if (md[h] ? k16 == p[31:16] || k16 == p[15:0] : ((k16 ^ p[31:16]) & p[15:0]) == 16'h0)
          return 1'b1;
      end
      return 1'b0;
    end
    if (md[0]) return k == fpat(f, 0) || k == fpat(f, 1);
    return ((k ^ fpat(f, 0)) & fpat(f, 1)) == 32'h0;
  endfunction
  function automatic logic [31:0] exp_rd(input logic [6:0] a);
    if (a == 7'h60) return {29'h0, m_pg};
    if (a == 7'h61) return {29'h0, txe, m_full};
    if (a[6:4] == 3'h7) return {24'h0, m_win[m_pg][a[3:0]]};
    return 32'h0;
  endfunction
  task automatic mwr(input logic [6:0] a, input logic [7:0] d);
    int k;
    logic [7:0] c;
    k = a[3:0];
    c = m_win[6][8 + m_pg] >> (k / 8 * 4);
    if (a == 7'h60) m_pg = d[2:0];
    if (a == 7'h61 && d[0]) m_full = 1'b0;
    if (a[6:4] != 3'h7) return;
    if (m_pg < 2 && txe[m_pg] && (k == 1 || (k > 3 && k < 14)))
      m_win[m_pg][k] = (k == 1) ? d & 8'h0F : d;
    if (m_pg inside {2, 3, 4} && !c[0]) m_win[m_pg][k] = d;
    if (m_pg == 6 && k > 7 && k < 13)
      m_win[6][k] = d & (k == 8 ? 8'hFF : k == 9 ? 8'h0F : 8'h77);
  endtask
  // ========================================================================
  // Bus transfer and frame delivery
  task automatic acc(input bit w, input logic [6:0] a, input logic [7:0] d);
    logic [31:0] e;
    int n;
    e = exp_rd(a);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= {24'($urandom), d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wq !== 1'b0 && n < 50);
    if (n >= 50) hang();
    if (!w) cmp_reg(rq, e);
    rd <= 1'b0;
    wr <= 1'b0;
    if (w && be[0]) mwr(a, d);
  endtask
  task automatic frame(input logic [31:0] k, input bit s);
    bit h;
    logic [7:0] ei;
    int n;
    h = 1'b0;
    ei = m_idx;
    for (int f = 5; f >= 0; f--) begin
      if (fhit(f, k)) begin
        h = 1'b1;
        ei = 8'(f);
      end
    end
    @(posedge clk);
    snd <= 1'b1;
    key <= k;
    ln <= 4'($urandom_range(8));
    dt <= {$urandom, $urandom};
    slow <= s;
    @(posedge clk);
    snd <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (xv !== 1'b1 && n < 20);
    if (n >= 20) hang();
    @(negedge clk);
    m_idx = ei;
    if (h && !m_full) begin
      m_full = 1'b1;
      m_win[7][0] = ei;
      m_win[7][1] = {4'h0, ln};
      m_win[7][5] = k[10:3];
      m_win[7][4] = k[18:11];
      for (int i = 0; i < 8; i++) m_win[7][6 + i] = dt[8 * i +: 8];
    end
    cmp_rx({acc_o, full, idx}, {h, m_full, ei});
  endtask
  // ========================================================================
  // Main sequence
  initial begin
    logic [31:0] p, q, k;
    int f;
    logic [1:0] sc;
    void'($urandom(32'h47C8));
    foreach (m_win[i, j]) m_win[i][j] = 8'h00;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    acc(0, 7'h60, 8'h00);
    acc(1, 7'h60, 8'h06);
    for (int j = 0; j < 16; j++) acc(0, 7'h70 + 7'(j), 8'h00);
    for (int j = 8; j < 13; j++) begin
      acc(1, 7'h70 + 7'(j), 8'($urandom));
      acc(0, 7'h70 + 7'(j), 8'h00);
    end
    be <= 4'h0;
    acc(1, 7'h7A, 8'h55);
    be <= 4'hF;
    acc(0, 7'h7A, 8'h00);
    for (int j = 10; j < 13; j++) acc(1, 7'h70 + 7'(j), 8'h00);
    // Mailboxes empty then busy, reserved page, receive page, unmapped index
    for (int s = 0; s < 6; s++) begin
      txe <= (s < 2) ? 2'h3 : 2'h0;
      acc(1, 7'h60, 8'(pgs[s]));
      for (int j = 0; j < 16; j++) acc(1, 7'h70 + 7'(j), 8'($urandom & 32'h7F));
      for (int j = 0; j < 16; j++) acc(0, 7'h70 + 7'(j), 8'h00);
    end
    acc(0, 7'h61, 8'h00);
    acc(1, 7'h10, 8'hA5);
    acc(0, 7'h10, 8'h00);
    // Filter bytes while inactive, then again after random activation
    for (int r = 0; r < 2; r++) begin
      for (int pg = 2; pg < 5; pg++) begin
        acc(1, 7'h60, 8'(pg));
        for (int j = 0; j < 16; j++) acc(1, 7'h70 + 7'(j), 8'($urandom));
        for (int j = 0; j < 16; j++) acc(0, 7'h70 + 7'(j), 8'h00);
      end
      acc(1, 7'h60, 8'h06);
      for (int j = 8; j < 13; j++)
        acc(1, 7'h70 + 7'(j), 8'($urandom) | (j > 9 && r == 0 ? 8'h66 : 8'h00));
    end
    // Frames aimed at random filters, mailbox drained every few frames
    acc(1, 7'h60, 8'h07);
    for (int t = 0; t < 48; t++) begin
      f = $urandom_range(5);
      p = fpat(f, 0);
      q = fpat(f, 1);
      k = t % 4 == 0 ? p : t % 4 == 1 ? q : t % 4 == 2 ? p ^ ($urandom & ~q) : $urandom;
      sc = 2'(m_win[6][10 + f / 2] >> (4 * (f % 2) + 1));
      if (sc != 2'h3) k[31 - 8 * sc -: 16] = k[31:16];
      k[0] = 1'b0;
      frame(k, t[0]);
      if (t % 6 == 5) begin
        for (int j = 0; j < 16; j++) acc(0, 7'h70 + 7'(j), 8'h00);
        acc(1, 7'h61, 8'h01);
        acc(0, 7'h61, 8'h00);
      end
    end
    tally_and_finish();
  end
endmodule // tb_top

// ==== rtl/cmf_byte_mem.sv ====
`timescale 1ns/1ps
`include "cmf_regs.svh"

module cmf_byte_mem
  import cmf_pkg::*;
(
  // Clock, reset, enable
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_ce,
  // Read port
  input  wire logic [5:0]   i_raddr,
  output logic      [7:0]   o_rdata,
  // Write port
  input  wire logic         i_we,
  input  wire logic [5:0]   i_waddr,
  input  wire logic [7:0]   i_wdata,
  // Whole contents for the matchers
  output logic      [383:0] o_flat
);

  cmf_mem_state_t st_ff;
  cmf_mem_state_t nxt_st;

  // ========================================================================
  // Next state: contents keep undefined reset value, read data cleared
  always_comb begin
    nxt_st = st_ff;
    if (i_ce) begin
      nxt_st.rdata = st_ff.mem[i_raddr];
      if (i_we) begin
        nxt_st.mem[i_waddr] = i_wdata;
      end
    end
    if (i_rst) begin
      nxt_st.rdata = `CMF_RST_BYTE;
    end
  end

  // State register
  always_ff @(posedge i_clk) begin
    st_ff <= nxt_st;
  end

  assign o_rdata = st_ff.rdata;
  assign o_flat  = st_ff.mem;

endmodule // cmf_byte_mem

// ==== rtl/cmf_filter_match.sv ====
`timescale 1ns/1ps
`include "cmf_regs.svh"

module cmf_filter_match
  import cmf_pkg::*;
(
  // Filter settings
  input  wire logic [63:0] i_bytes,
  input  wire logic        i_active,
  input  wire logic [1:0]  i_scale,
  input  wire logic        i_mode_lo,
  input  wire logic        i_mode_hi,
  // Received frame key
  input  wire logic [31:0] i_key,
  // Result
  output logic             o_hit
);

  // ========================================================================
  // Compare functions: list mode matches either pattern, mask mode masks
  function automatic logic cmp16(input logic [15:0] k, input logic [15:0] p,
                                 input logic [15:0] q, input logic list);
    if (list) begin
      cmp16 = (k == p) || (k == q);
    end else begin
      cmp16 = ((k ^ p) & q) == 16'h0000;
    end
  endfunction

  function automatic logic cmp32(input logic [31:0] k, input logic [31:0] p,
                                 input logic [31:0] q, input logic list);
    if (list) begin
      cmp32 = (k == p) || (k == q);
    end else begin
      cmp32 = ((k ^ p) & q) == 32'h0000_0000;
    end
  endfunction

  // ========================================================================
  // Byte roles follow scale and half modes; mask bytes map like id bytes
  logic [15:0] key16;
  logic        hit_lo;
  logic        hit_hi;
  logic        hit_full;

  always_comb begin
    case (i_scale)
      2'h0:    key16 = i_key[31:16];
      2'h1:    key16 = i_key[23:8];
      default: key16 = i_key[15:0];
    endcase
    hit_lo   = cmp16(key16, {i_bytes[7:0], i_bytes[15:8]},
                     {i_bytes[23:16], i_bytes[31:24]}, i_mode_lo);
    hit_hi   = cmp16(key16, {i_bytes[39:32], i_bytes[47:40]},
                     {i_bytes[55:48], i_bytes[63:56]}, i_mode_hi);
    hit_full = cmp32(i_key, {i_bytes[7:0], i_bytes[15:8], i_bytes[23:16], i_bytes[31:24]},
                     {i_bytes[39:32], i_bytes[47:40], i_bytes[55:48], i_bytes[63:56]},
                     i_mode_lo);
    if (!i_active) begin
      o_hit = 1'b0;
    end else if (i_scale == `CMF_SCALE_FULL) begin
      o_hit = hit_full;
    end else begin
      o_hit = hit_lo || hit_hi;
    end
  end

endmodule // cmf_filter_match

// ==== rtl/cmf_pkg.sv ====
package cmf_pkg;

  // ========================================================================
  // Bus answer sequence
  typedef enum logic [1:0] {
    CMF_IDLE,
    CMF_FETCH,
    CMF_ANSWER
  } cmf_bus_state_t;

  // ========================================================================
  // State of the filter byte memory
  typedef struct packed {
    logic [47:0][7:0] mem;
    logic [7:0]       rdata;
  } cmf_mem_state_t;

  // ========================================================================
  // State of the top module
  typedef struct packed {
    cmf_bus_state_t        st;
    logic [31:0]           rdata;
    logic                  waitreq;
    logic [2:0]            page;
    logic [2:0][7:0]       cfg;
    logic [7:0]            mode_lo;
    logic [7:0]            mode_hi;
    logic [1:0][7:0]       tx_idmid;
    logic [1:0][7:0]       tx_idlo;
    logic [1:0][3:0]       tx_dlc;
    logic [1:0][7:0][7:0]  tx_data;
    logic [7:0]            rx_idmid;
    logic [7:0]            rx_idlo;
    logic [3:0]            rx_dlc;
    logic [7:0][7:0]       rx_data;
    logic [7:0]            rx_fmi;
    logic                  rx_full;
    logic                  accept;
    logic [7:0]            match_idx;
  } cmf_top_state_t;

endpackage

// ==== rtl/cmf_regs.svh ====
`ifndef CMF_REGS_SVH
`define CMF_REGS_SVH

// ==========================================================================
// Register indexes (Avalon word address = index)
`define CMF_OFF_PAGE        7'h60
`define CMF_OFF_RX_STATUS   7'h61
`define CMF_WIN_BASE        7'h70

// ==========================================================================
// Offsets inside the paged window (low nibble of the index)
`define CMF_K_STATUS        4'h0
`define CMF_K_DLC           4'h1
`define CMF_K_IDMID         4'h4
`define CMF_K_IDLO          4'h5
`define CMF_K_DATA0         4'h6
`define CMF_K_DATA7         4'hD
`define CMF_K_MODE_LO       4'h8
`define CMF_K_MODE_HI       4'h9
`define CMF_K_CFG0          4'hA
`define CMF_K_CFG2          4'hC

// ==========================================================================
// Page numbers
`define CMF_PG_TX0          3'h0
`define CMF_PG_TX1          3'h1
`define CMF_PG_FLT01        3'h2
`define CMF_PG_FLT45        3'h4
`define CMF_PG_CONF         3'h6
`define CMF_PG_RX           3'h7

// ==========================================================================
// Field positions and write masks
`define CMF_ODD_ACT         4
`define CMF_EVEN_ACT        0
`define CMF_ODD_SCALE_LSB   5
`define CMF_EVEN_SCALE_LSB  1
`define CMF_CFG_WMASK       8'h77
`define CMF_MODE_HI_WMASK   8'h0F
`define CMF_RXST_FULL       0
`define CMF_RXST_TXE_LSB    1
`define CMF_SCALE_FULL      2'h3

// ==========================================================================
// Reset values and sizes
`define CMF_RST_BYTE        8'h00
`define CMF_RST_WORD        32'h0000_0000
`define CMF_FLT_BYTES       48

`endif

// ==== rtl/cmf_top.sv ====
// Contract
// - Id byte: extended bits 15..8, bit15 on top
// - Last id byte: identifier bit n in bit n
// - Length register locked while mailbox not empty
// - Length bits 6:4 read zero, code 3:0
// - Eight payload bytes, locked while not empty
// - Config: odd filter high nibble, even low
// - Config bits 7 and 3 read zero
// - Activate enables filter; clear before editing
// - Three config registers, pairs ascending, reset zero
// - Per-half mode: zero mask, one list
// - First mode register: filters 3..0, reset zero
// - Second mode register: filters 5,4; top zero
// - Identifier bit: zero dominant, one recessive
// - Mask bit zero ignores, one must match
// - Eight undefined bytes per filter, role by settings
// - Mask byte maps bits like identifier byte
// - Page number selects window contents
// - Receive mailbox read only; transmit writable empty
// - Filter page: even 70h-77h, odd 78h-7Fh
`timescale 1ns/1ps
`include "cmf_regs.svh"

module cmf_top
  import cmf_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        I_MCLK,
  input  wire logic        I_RST,
  input  wire logic        I_CE,
  // Avalon-MM slave
  input  wire logic [6:0]  I_AVS_ADDRESS,
  input  wire logic        I_AVS_READ,
  input  wire logic        I_AVS_WRITE,
  input  wire logic [31:0] I_AVS_WRITEDATA,
  input  wire logic [3:0]  I_AVS_BYTEENABLE,
  output logic      [31:0] O_AVS_READDATA,
  output logic             O_AVS_WAITREQUEST,
  // Transmit mailbox empty flags from the transmit engine
  input  wire logic [1:0]  I_TX_EMPTY,
  // Received frame from the protocol engine
  input  wire logic        I_RX_VALID,
  input  wire logic [28:0] I_RX_ID,
  input  wire logic        I_RX_IDE,
  input  wire logic        I_RX_RTR,
  input  wire logic [3:0]  I_RX_DLC,
  input  wire logic [63:0] I_RX_DATA,
  // Acceptance result
  output logic             O_RX_ACCEPT,
  output logic      [7:0]  O_RX_MATCH_INDEX,
  output logic             O_RX_FULL
);

  // ========================================================================
  // Decode helpers
  function automatic logic in_window(input logic [6:0] a);
    in_window = (a[6:4] == `CMF_WIN_BASE >> 4);
  endfunction

  function automatic logic filter_activate_of(input logic [2:0][7:0] c, input logic [2:0] f);
    logic [7:0] r;
    r = c[f[2:1]];
    filter_activate_of = f[0] ? r[`CMF_ODD_ACT] : r[`CMF_EVEN_ACT];
  endfunction

  function automatic logic [1:0] scale_of(input logic [2:0][7:0] c, input logic [2:0] f);
    logic [7:0] r;
    r = c[f[2:1]];
    scale_of = f[0] ? r[`CMF_ODD_SCALE_LSB +: 2] : r[`CMF_EVEN_SCALE_LSB +: 2];
  endfunction

  function automatic logic [7:0] first_hit(input logic [5:0] h);
    first_hit = `CMF_RST_BYTE;
    for (int i = 5; i >= 0; i--) begin
      if (h[i]) begin
        first_hit = 8'(i);
      end
    end
  endfunction

  cmf_top_state_t st_ff;
  cmf_top_state_t nxt_st;

  logic         req;
  logic [3:0]   k;
  logic [2:0]   pg;
  logic [2:0]   flt_sel;
  logic [5:0]   mem_addr;
  logic [7:0]   mem_rdata;
  logic [383:0] mem_flat;
  logic         mem_we;
  logic [7:0]   rd_byte;
  logic [7:0]   wbyte;
  logic         wr_ok;
  logic [2:0]   didx;
  logic         mbx;
  logic [31:0]  key;
  logic [5:0]   hits;
  logic         is_data;

  // ========================================================================
  // Window address split: page, offset, filter memory address
  assign req      = I_AVS_READ || I_AVS_WRITE;
  assign k        = I_AVS_ADDRESS[3:0];
  assign pg       = st_ff.page;
  assign flt_sel  = {3'(pg - `CMF_PG_FLT01)} << 1 | {2'h0, k[3]};
  assign mem_addr = {2'(pg - `CMF_PG_FLT01), k};
  assign didx     = 3'(k - `CMF_K_DATA0);
  assign mbx      = pg[0];
  assign wbyte    = I_AVS_WRITEDATA[7:0];
  assign is_data  = (k >= `CMF_K_DATA0) && (k <= `CMF_K_DATA7);
  assign key      = {I_RX_ID, I_RX_IDE, I_RX_RTR, 1'b0};

  // ========================================================================
  // Filter byte storage
  cmf_byte_mem u_mem (
    .i_clk   (I_MCLK),
    .i_rst   (I_RST),
    .i_ce    (I_CE),
    .i_raddr (mem_addr),
    .o_rdata (mem_rdata),
    .i_we    (mem_we),
    .i_waddr (mem_addr),
    .i_wdata (wbyte),
    .o_flat  (mem_flat)
  );

  // ========================================================================
  // Six filter matchers
  for (genvar f = 0; f < 6; f++) begin : g_flt
    cmf_filter_match u_match (
      .i_bytes   (mem_flat[f*64 +: 64]),
      .i_active  (filter_activate_of(st_ff.cfg, 3'(f))),
      .i_scale   (scale_of(st_ff.cfg, 3'(f))),
      .i_mode_lo (f < 4 ? st_ff.mode_lo[2*(f%4)] : st_ff.mode_hi[2*(f%4)]),
      .i_mode_hi (f < 4 ? st_ff.mode_lo[2*(f%4)+1] : st_ff.mode_hi[2*(f%4)+1]),
      .i_key     (key),
      .o_hit     (hits[f])
    );
  end

  // ========================================================================
  // Read data of the addressed byte
  always_comb begin
    rd_byte = `CMF_RST_BYTE;
    if (I_AVS_ADDRESS == `CMF_OFF_PAGE) begin
      rd_byte = {5'h00, st_ff.page};
    end else if (I_AVS_ADDRESS == `CMF_OFF_RX_STATUS) begin
      rd_byte = {5'h00, I_TX_EMPTY, st_ff.rx_full};
    end else if (in_window(I_AVS_ADDRESS)) begin
      case (pg)
        `CMF_PG_TX0, `CMF_PG_TX1: begin
          if (k == `CMF_K_DLC) begin
            rd_byte = {4'h0, st_ff.tx_dlc[mbx]};
          end else if (k == `CMF_K_IDMID) begin
            rd_byte = st_ff.tx_idmid[mbx];
          end else if (k == `CMF_K_IDLO) begin
            rd_byte = st_ff.tx_idlo[mbx];
          end else if (is_data) begin
            rd_byte = st_ff.tx_data[mbx][didx];
          end
        end
        3'h2, 3'h3, `CMF_PG_FLT45: begin
          rd_byte = mem_rdata;
        end
        `CMF_PG_CONF: begin
          if (k == `CMF_K_MODE_LO) begin
            rd_byte = st_ff.mode_lo;
          end else if (k == `CMF_K_MODE_HI) begin
            rd_byte = st_ff.mode_hi;
          end else if (k >= `CMF_K_CFG0 && k <= `CMF_K_CFG2) begin
            rd_byte = st_ff.cfg[2'(k - `CMF_K_CFG0)];
          end
        end
        `CMF_PG_RX: begin
          if (k == `CMF_K_STATUS) begin
            rd_byte = st_ff.rx_fmi;
          end else if (k == `CMF_K_DLC) begin
            rd_byte = {4'h0, st_ff.rx_dlc};
          end else if (k == `CMF_K_IDMID) begin
            rd_byte = st_ff.rx_idmid;
          end else if (k == `CMF_K_IDLO) begin
            rd_byte = st_ff.rx_idlo;
          end else if (is_data) begin
            rd_byte = st_ff.rx_data[didx];
          end
        end
        default: rd_byte = `CMF_RST_BYTE;
      endcase
    end
  end

  // ========================================================================
  // Write permission of the addressed window byte
  always_comb begin
    wr_ok = 1'b0;
    if (in_window(I_AVS_ADDRESS) && I_AVS_BYTEENABLE[0]) begin
      case (pg)
        `CMF_PG_TX0, `CMF_PG_TX1: wr_ok = I_TX_EMPTY[mbx];
        3'h2, 3'h3, `CMF_PG_FLT45: wr_ok = !filter_activate_of(st_ff.cfg, flt_sel);
        `CMF_PG_CONF: wr_ok = 1'b1;
        default: wr_ok = 1'b0;
      endcase
    end
  end

  assign mem_we = I_CE && (st_ff.st == CMF_ANSWER) && I_AVS_WRITE && wr_ok &&
                  (pg >= `CMF_PG_FLT01) && (pg <= `CMF_PG_FLT45);

  // ========================================================================
  // Next state
  always_comb begin
    nxt_st = st_ff;
    if (I_CE) begin
      nxt_st.accept = 1'b0;
      case (st_ff.st)
        CMF_IDLE: begin
          if (req) begin
            nxt_st.st = CMF_FETCH;
          end
        end
        CMF_FETCH: begin
          nxt_st.st      = CMF_ANSWER;
          nxt_st.waitreq = 1'b0;
          nxt_st.rdata   = {24'h00_0000, rd_byte};
        end
        default: begin
          nxt_st.st      = CMF_IDLE;
          nxt_st.waitreq = 1'b1;
          if (I_AVS_WRITE && I_AVS_BYTEENABLE[0]) begin
            if (I_AVS_ADDRESS == `CMF_OFF_PAGE) begin
              nxt_st.page = wbyte[2:0];
            end else if (I_AVS_ADDRESS == `CMF_OFF_RX_STATUS) begin
              if (wbyte[`CMF_RXST_FULL]) begin
                nxt_st.rx_full = 1'b0;
              end
            end else if (wr_ok && pg <= `CMF_PG_TX1) begin
              if (k == `CMF_K_DLC) begin
                nxt_st.tx_dlc[mbx] = wbyte[3:0];
              end else if (k == `CMF_K_IDMID) begin
                nxt_st.tx_idmid[mbx] = wbyte;
              end else if (k == `CMF_K_IDLO) begin
                nxt_st.tx_idlo[mbx] = wbyte;
              end else if (is_data) begin
                nxt_st.tx_data[mbx][didx] = wbyte;
              end
            end else if (wr_ok && pg == `CMF_PG_CONF) begin
              if (k == `CMF_K_MODE_LO) begin
                nxt_st.mode_lo = wbyte;
              end else if (k == `CMF_K_MODE_HI) begin
                nxt_st.mode_hi = wbyte & `CMF_MODE_HI_WMASK;
              end else if (k >= `CMF_K_CFG0 && k <= `CMF_K_CFG2) begin
                nxt_st.cfg[2'(k - `CMF_K_CFG0)] = wbyte & `CMF_CFG_WMASK;
              end
            end
          end
        end
      endcase
      // Frame acceptance; a load after a clear in the same cycle wins
      if (I_RX_VALID && (hits != 6'h00)) begin
        nxt_st.accept    = 1'b1;
        nxt_st.match_idx = first_hit(hits);
        if (!nxt_st.rx_full) begin
          nxt_st.rx_full = 1'b1;
          nxt_st.rx_fmi  = first_hit(hits);
          nxt_st.rx_idlo = I_RX_ID[7:0];
          nxt_st.rx_idmid = I_RX_ID[15:8];
          nxt_st.rx_dlc  = I_RX_DLC;
          nxt_st.rx_data = I_RX_DATA;
        end
      end
    end
    if (I_RST) begin
      nxt_st         = '0;
      nxt_st.st      = CMF_IDLE;
      nxt_st.waitreq = 1'b1;
    end
  end

  // State register
  always_ff @(posedge I_MCLK) begin
    st_ff <= nxt_st;
  end

  // ========================================================================
  // Outputs, all from the state register
  assign O_AVS_READDATA    = st_ff.rdata;
  assign O_AVS_WAITREQUEST = st_ff.waitreq;
  assign O_RX_ACCEPT       = st_ff.accept;
  assign O_RX_MATCH_INDEX  = st_ff.match_idx;
  assign O_RX_FULL         = st_ff.rx_full;

endmodule // cmf_top
